// ---- hw/bcuh_config_upper.v ----
// Functional notes
// [R1] Prefetch base upper dword, RW, reset zero
// [R2] Prefetch limit upper dword, RW, reset zero
// [R3] I/O base upper half, RW, reset zero
// [R4] I/O limit upper half, RW, reset zero
// [R5] Capability pointer reads constant 80h
// [R6] Option ROM base reads zero, ignores writes
// [R7] Interrupt line byte RW, no effect
// [R8] Interrupt pin byte reads 00h
// [R9] Discard expiry drives upstream error when enabled; here no error while the primary side is in PCI-X mode
// [R10] Discard status sticky, write-one clears; here held clear while the primary side is in PCI-X mode
// [R11] Bit 25 picks secondary timer length
// [R12] Bit 24 picks primary timer length
// [R13] Fast back-to-back bit reads zero
// [R14] Bit 22 holds downstream reset asserted
// [R15] Abort mode clear: ones, discard, silent
// [R16] Abort mode set: target abort or error
// [R17] PCI-X non-posted abort gives split completion
// [R18] VGA enable forwards compatible ranges downstream
// [R19] ISA enable sends low 64KB window upstream
// [R20] Bit 17 forwards downstream error upstream
// [R21] Bit 16 enables downstream parity checking
// [R22] Reserved control bits read zero
// [R23] Prefetch fields report 64-bit capability
// [R24] Writes honour byte enables
`include "bcuh_consts.vh"

module bcuh_config_upper #(
    parameter DT_LONG = `BCUH_DT_LONG,
    parameter DT_SHORT = `BCUH_DT_SHORT
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Configuration access
    input wire cfgWrite,
    input wire cfgRead,
    input wire [7:0] cfgAddr,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgWriteData,
    output reg [31:0] cfgReadData,
    output reg cfgReadValid,
    // Bus mode and command state
    input wire [1:0] pciXMode,
    input wire ioEnable,
    input wire memEnable,
    input wire serrEnable,
    // Discard timers
    input wire [1:0] delayedPending,
    output reg [1:0] discardExpired,
    // System error
    input wire downstreamSystemErrorN,
    output reg upstreamSystemErrorN,
    // Downstream bus control
    output reg downstreamResetN,
    output reg parityCheckEnable,
    output reg fastBackToBack,
    output reg [3:0] prefetchAddrCap,
    // Master abort handling
    input wire abortValid,
    input wire abortPosted,
    input wire abortCanTarget,
    output reg abortFillOnes,
    output reg abortTargetAbort,
    output reg abortSplitDone,
    // Forwarding decision
    input wire fwdValid,
    input wire fwdIsIo,
    input wire [31:0] fwdAddr,
    input wire inIoWindow,
    input wire inMemWindow,
    output reg fwdDone,
    output reg fwdDownstream
);

    // Header storage
    reg [31:0] pfBaseHigh;
    reg [31:0] pfLimitHigh;
    reg [15:0] ioBaseHigh;
    reg [15:0] ioLimitHigh;
    reg [7:0] intLine;
    // Writable bridge control bits
    reg parityResp;
    reg serrForward;
    reg isaMode;
    reg vgaMode;
    reg abortMode;
    reg secReset;
    reg priShort;
    reg secShort;
    reg dtSerrEn;
    reg dtStatus;

    // Expiry strobes, one per side
    // Each side's count lives in its own generate block
    wire [1:0] dtHit;

    // Decoded accesses
    wire wrIo = cfgWrite && (cfgAddr == `BCUH_OFF_IO_HI);
    wire wrCtl = cfgWrite && (cfgAddr == `BCUH_OFF_INT_BRCTL);
    wire wrPfB = cfgWrite && (cfgAddr == `BCUH_OFF_PF_BASE_HI);
    wire wrPfL = cfgWrite && (cfgAddr == `BCUH_OFF_PF_LIMIT_HI);

    // Byte mask from the enables
    wire [31:0] beMask = {{8{cfgByteEn[3]}}, {8{cfgByteEn[2]}},
                          {8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};

    // Expiry visible only outside PCI-X on the primary side
    wire dtEvent = |dtHit && !pciXMode[0];

    // Timer count selection and per-side counters
    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1)
        begin : gTimer
            // Clocks spent waiting on this side; one owner per counter
            reg [15:0] dtCnt;
            // Short length when the side's select bit is set
            wire shortSel = (s == 0) ? priShort : secShort; // [R11] [R12]
            // Limitation: 16-bit count, so lengths stay at or below 65536
            // A select change mid-count applies at once, without restart
            wire [15:0] lastCnt = shortSel ? DT_SHORT[15:0] - 16'h0001
                                           : DT_LONG[15:0] - 16'h0001;
            // A side in PCI-X mode never expires
            assign dtHit[s] = delayedPending[s] && !pciXMode[s]
                              && (dtCnt == lastCnt);
            // Counter restarts whenever nothing waits
            always @(posedge core_clk)
            begin
                if (sys_rst || !delayedPending[s] || pciXMode[s] || dtHit[s])
                begin
                    dtCnt <= 16'h0000;
                end
                else
                begin
                    dtCnt <= dtCnt + 16'h0001;
                end
            end
        end
    endgenerate

    // Merge write data under byte enables
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [31:0] mask;
        begin
            merge = (old & ~mask) | (data & mask);
        end
    endfunction

    // Assembled 3Ch dword; reserved bits tie low
    wire [31:0] ctlWord = {4'h0, dtSerrEn, dtStatus, secShort, priShort,
                           1'b0, secReset, abortMode, 1'b0, // [R13] [R22]
                           vgaMode, isaMode, serrForward, parityResp,
                           `BCUH_INT_PIN_VAL, intLine}; // [R8]
    wire [31:0] ctlMerged = merge(ctlWord, cfgWriteData, beMask);
    // Merged 30h dword; base takes lanes 1:0, limit lanes 3:2
    // Cutting it by part-select keeps each half exactly 16 bits
    wire [31:0] ioMerged = merge({ioLimitHigh, ioBaseHigh}, cfgWriteData, beMask);

    // Writable registers
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pfBaseHigh <= `BCUH_RST_PF_HI;
            pfLimitHigh <= `BCUH_RST_PF_HI;
            ioBaseHigh <= `BCUH_RST_IO_HI;
            ioLimitHigh <= `BCUH_RST_IO_HI;
            intLine <= `BCUH_RST_INT_LINE;
            parityResp <= 1'b0;
            serrForward <= 1'b0;
            isaMode <= 1'b0;
            vgaMode <= 1'b0;
            abortMode <= 1'b0;
            secReset <= 1'b0;
            priShort <= 1'b0;
            secShort <= 1'b0;
            dtSerrEn <= 1'b0;
        end
        else
        begin
            // Full dword registers
            if (wrPfB)
            begin
                pfBaseHigh <= merge(pfBaseHigh, cfgWriteData, beMask); // [R1] [R24]
            end
            if (wrPfL)
            begin
                pfLimitHigh <= merge(pfLimitHigh, cfgWriteData, beMask); // [R2] [R24]
            end
            // Base and limit halves share one dword
            if (wrIo)
            begin
                // Each half keeps its own lanes of the merged dword
                ioBaseHigh <= ioMerged[15:0]; // [R3] [R24]
                ioLimitHigh <= ioMerged[31:16]; // [R4] [R24]
            end
            // Line byte and control bits, each lane on its own
            if (wrCtl)
            begin
                intLine <= ctlMerged[7:0]; // [R7] [R24]
                parityResp <= ctlMerged[`BCUH_BIT_PAR_RESP]; // [R21]
                serrForward <= ctlMerged[`BCUH_BIT_SERR_FWD]; // [R20]
                isaMode <= ctlMerged[`BCUH_BIT_ISA]; // [R19]
                vgaMode <= ctlMerged[`BCUH_BIT_VGA]; // [R18]
                abortMode <= ctlMerged[`BCUH_BIT_MA_MODE]; // [R15] [R16]
                secReset <= ctlMerged[`BCUH_BIT_SEC_RST]; // [R14]
                priShort <= ctlMerged[`BCUH_BIT_PRI_SHORT]; // [R12]
                secShort <= ctlMerged[`BCUH_BIT_SEC_SHORT]; // [R11]
                dtSerrEn <= ctlMerged[`BCUH_BIT_DT_SERR]; // [R9]
            end
        end
    end

    // Sticky discard status; a new expiry beats a clear
    wire dtClear = wrCtl && cfgByteEn[3] && cfgWriteData[`BCUH_BIT_DT_STAT];
    always @(posedge core_clk)
    begin
        if (sys_rst || pciXMode[0])
        begin
            dtStatus <= 1'b0; // [R10]
        end
        else
        begin
            dtStatus <= (dtStatus && !dtClear) || dtEvent; // [R10]
        end
    end

    // Read mux; ROM and unmapped offsets answer zero
    reg [31:0] next_readData;
    always @*
    begin
        next_readData = 32'h00000000;
        case (cfgAddr)
            `BCUH_OFF_PF_BASE_HI: next_readData = pfBaseHigh;
            `BCUH_OFF_PF_LIMIT_HI: next_readData = pfLimitHigh;
            `BCUH_OFF_IO_HI: next_readData = {ioLimitHigh, ioBaseHigh};
            `BCUH_OFF_CAP_PTR: next_readData = {24'h000000, `BCUH_CAP_PTR_VAL}; // [R5]
            `BCUH_OFF_ROM_BASE: next_readData = `BCUH_ROM_BASE_VAL; // [R6]
            `BCUH_OFF_INT_BRCTL: next_readData = ctlWord;
            default: next_readData = 32'h00000000;
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cfgReadData <= 32'h00000000;
            cfgReadValid <= 1'b0;
        end
        else
        begin
            cfgReadValid <= cfgRead;
            if (cfgRead)
            begin
                cfgReadData <= next_readData;
            end
        end
    end

    // Abort reporting through the error pin needs enable
    wire abortReport = abortValid && !(pciXMode[0] && !abortPosted)
                       && abortMode && !abortCanTarget;
    wire abortSerr = abortReport && serrEnable; // [R16]

    // Upstream error, active low, registered one cycle after any cause
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            upstreamSystemErrorN <= 1'b1;
        end
        else
        begin
            upstreamSystemErrorN <= !((dtSerrEn && dtEvent) // [R9]
                || (serrForward && !downstreamSystemErrorN) // [R20]
                || abortSerr); // [R16]
        end
    end

    // Level outputs from control bits and constants, and the expiry strobes
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            downstreamResetN <= 1'b1;
            parityCheckEnable <= 1'b0;
            fastBackToBack <= 1'b0;
            prefetchAddrCap <= `BCUH_PF_ADDR_CAP;
            discardExpired <= 2'b00;
        end
        else
        begin
            downstreamResetN <= !secReset; // [R14]
            parityCheckEnable <= parityResp; // [R21]
            fastBackToBack <= 1'b0; // [R13]
            prefetchAddrCap <= `BCUH_PF_ADDR_CAP; // [R23]
            discardExpired <= dtHit;
        end
    end

    // Master abort outcome, one-cycle pulses
    always @(posedge core_clk)
    begin
        if (sys_rst || !abortValid)
        begin
            abortFillOnes <= 1'b0;
            abortTargetAbort <= 1'b0;
            abortSplitDone <= 1'b0;
        end
        else if (pciXMode[0] && !abortPosted)
        begin
            // Host supplies the ones after the split message
            abortFillOnes <= 1'b0;
            abortTargetAbort <= 1'b0;
            abortSplitDone <= 1'b1; // [R17]
        end
        else if (!abortMode)
        begin
            // Silent: ones on reads, writes dropped
            abortFillOnes <= 1'b1; // [R15]
            abortTargetAbort <= 1'b0;
            abortSplitDone <= 1'b0;
        end
        else
        begin
            abortFillOnes <= 1'b0;
            abortTargetAbort <= abortCanTarget; // [R16]
            abortSplitDone <= 1'b0;
        end
    end

    // Compatible-range and window decoding
    wire vgaMem = !fwdIsIo && fwdAddr >= `BCUH_VGA_MEM_LO
                  && fwdAddr <= `BCUH_VGA_MEM_HI;
    wire [9:0] ioLow = fwdAddr[9:0];
    wire vgaIo = fwdIsIo && fwdAddr <= `BCUH_IO_64K_TOP
                 && ((ioLow >= `BCUH_VGA_IO_A_LO && ioLow <= `BCUH_VGA_IO_A_HI)
                 || (ioLow >= `BCUH_VGA_IO_B_LO && ioLow <= `BCUH_VGA_IO_B_HI));
    wire spaceOn = fwdIsIo ? ioEnable : memEnable;
    wire inWin = fwdIsIo ? inIoWindow : inMemWindow;
    // ISA mode pulls low window I/O back upstream
    wire isaBack = isaMode && fwdIsIo && fwdAddr <= `BCUH_IO_64K_TOP; // [R19]

    // Forwarding answer, one cycle after the request
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            fwdDone <= 1'b0;
            fwdDownstream <= 1'b0;
        end
        else
        begin
            fwdDone <= fwdValid;
            if (fwdValid)
            begin
                if (vgaMode && (vgaMem || vgaIo))
                begin
                    fwdDownstream <= spaceOn; // [R18]
                end
                else
                begin
                    fwdDownstream <= spaceOn && inWin && !isaBack; // [R18] [R19]
                end
            end
        end
    end

endmodule

// ---- include/bcuh_consts.vh ----
`ifndef BCUH_CONSTS_VH
`define BCUH_CONSTS_VH

// Dword offsets of the upper type 1 header
`define BCUH_OFF_PF_BASE_HI 8'h28
`define BCUH_OFF_PF_LIMIT_HI 8'h2c
`define BCUH_OFF_IO_HI 8'h30
`define BCUH_OFF_CAP_PTR 8'h34
`define BCUH_OFF_ROM_BASE 8'h38
`define BCUH_OFF_INT_BRCTL 8'h3c

// Fixed read values
`define BCUH_CAP_PTR_VAL 8'h80
`define BCUH_ROM_BASE_VAL 32'h00000000
`define BCUH_INT_PIN_VAL 8'h00
`define BCUH_PF_ADDR_CAP 4'h1
`define BCUH_ALL_ONES 32'hffffffff

// Reset values
`define BCUH_RST_PF_HI 32'h00000000
`define BCUH_RST_IO_HI 16'h0000
`define BCUH_RST_INT_LINE 8'h00

// Bridge control bit positions within the 3Ch dword
`define BCUH_BIT_PAR_RESP 16
`define BCUH_BIT_SERR_FWD 17
`define BCUH_BIT_ISA 18
`define BCUH_BIT_VGA 19
`define BCUH_BIT_MA_MODE 21
`define BCUH_BIT_SEC_RST 22
`define BCUH_BIT_PRI_SHORT 24
`define BCUH_BIT_SEC_SHORT 25
`define BCUH_BIT_DT_STAT 26
`define BCUH_BIT_DT_SERR 27

// Discard timer lengths in bus clocks
`define BCUH_DT_LONG 32768
`define BCUH_DT_SHORT 1024

// Compatible address ranges
`define BCUH_VGA_MEM_LO 32'h000a0000
`define BCUH_VGA_MEM_HI 32'h000bffff
`define BCUH_VGA_IO_A_LO 10'h3b0
`define BCUH_VGA_IO_A_HI 10'h3bb
`define BCUH_VGA_IO_B_LO 10'h3c0
`define BCUH_VGA_IO_B_HI 10'h3df
`define BCUH_IO_64K_TOP 32'h0000ffff

`endif

// ---- verification/bcuh_checker.sv ----
module bcuh_checker #(
    parameter DT_LONG = 32768,
    parameter DT_SHORT = 1024
) (
    // Clock, reset and register access
    input wire core_clk, sys_rst, cfgWrite, cfgRead, cfgReadValid,
    input wire [7:0] cfgAddr,
    input wire [3:0] cfgByteEn,
    input wire [31:0] cfgWriteData, cfgReadData, fwdAddr,
    // Side inputs and outputs
    input wire [1:0] pciXMode, delayedPending, discardExpired,
    input wire memEnable, ioEnable, downstreamSystemErrorN, upstreamSystemErrorN,
    input wire downstreamResetN, parityCheckEnable, abortValid, abortPosted,
    input wire abortFillOnes, abortSplitDone, fwdValid, fwdIsIo, fwdDone, fwdDownstream
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [15:0] ctl; // Copy of control bits 31:16
    reg [15:0] pCnt; // Primary pending edges
    wire [15:0] pLen = ctl[8] ? 16'(DT_SHORT) : 16'(DT_LONG);
    wire split = pciXMode[0] && !abortPosted;
    // Mirror lane writes; counter restarts when pending drops or the primary side enters PCI-X mode
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctl <= 16'h0000;
            pCnt <= 16'h0000;
        end
        else
        begin
            if (cfgWrite && cfgAddr == 8'h3c && cfgByteEn[2])
                ctl[7:0] <= cfgWriteData[23:16];
            if (cfgWrite && cfgAddr == 8'h3c && cfgByteEn[3])
                ctl[15:8] <= cfgWriteData[31:24];
            pCnt <= (delayedPending[0] && !pciXMode[0]) ? pCnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    a_rom_reads_zero: assert property (
        cfgRead && cfgAddr == 8'h38 |=> cfgReadValid && cfgReadData == 32'h00000000)
        else $error("option rom read not zero");
    a_fixed_bits_zero: assert property (
        cfgRead && cfgAddr == 8'h3c |=> (cfgReadData & 32'hf090ff00) == 32'h00000000)
        else $error("read-only control bits not zero");
    a_ctl_outputs_follow: assert property (
        $stable(ctl) |-> downstreamResetN == !ctl[6] && parityCheckEnable == ctl[0])
        else $error("reset or parity output off");
    a_serr_forward: assert property (
        !downstreamSystemErrorN && ctl[1] |=> !upstreamSystemErrorN)
        else $error("downstream error not forwarded");
    a_serr_has_cause: assert property (
        !upstreamSystemErrorN |-> $past(!downstreamSystemErrorN && ctl[1])
            || (|discardExpired && ctl[11]) || $past(abortValid))
        else $error("upstream error without cause");
    a_discard_length: assert property (
        discardExpired[0] |-> pCnt != 16'h0000 && pCnt % pLen == 16'h0000)
        else $error("primary discard length wrong");
    a_abort_split: assert property (
        abortValid && split |=> abortSplitDone && !abortFillOnes)
        else $error("split completion missing");
    a_abort_ones: assert property (
        abortValid && !split && !ctl[5] |=> abortFillOnes && upstreamSystemErrorN)
        else $error("silent abort wrong");
    a_isa_upstream: assert property (
        fwdValid && fwdIsIo && ctl[2] && !ctl[3] && fwdAddr <= 32'h0000ffff
            |=> fwdDone && !fwdDownstream)
        else $error("low io sent downstream");
    a_vga_forward: assert property (
        fwdValid && ctl[3] && !fwdIsIo && memEnable && ioEnable
            && fwdAddr >= 32'h000a0000 && fwdAddr <= 32'h000bffff |=> fwdDone && fwdDownstream)
        else $error("vga memory not forwarded");
endmodule
bind bcuh_config_upper bcuh_checker #(.DT_LONG(DT_LONG), .DT_SHORT(DT_SHORT)) chk_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgReadValid(cfgReadValid), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
    .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData), .fwdAddr(fwdAddr),
    .pciXMode(pciXMode), .delayedPending(delayedPending), .discardExpired(discardExpired),
    .memEnable(memEnable), .ioEnable(ioEnable),
    .downstreamSystemErrorN(downstreamSystemErrorN),
    .upstreamSystemErrorN(upstreamSystemErrorN), .downstreamResetN(downstreamResetN),
    .parityCheckEnable(parityCheckEnable), .abortValid(abortValid),
    .abortPosted(abortPosted), .abortFillOnes(abortFillOnes),
    .abortSplitDone(abortSplitDone), .fwdValid(fwdValid), .fwdIsIo(fwdIsIo),
    .fwdDone(fwdDone), .fwdDownstream(fwdDownstream));

// ---- verification/bcuh_host.sv ----
module bcuh_host (
    // Clock
    input wire core_clk,
    // Requests toward the bridge
    output logic cfgWrite,
    output logic cfgRead,
    output logic [7:0] cfgAddr,
    output logic [3:0] cfgByteEn,
    output logic [31:0] cfgWriteData,
    // Answer
    input wire [31:0] cfgReadData,
    input wire cfgReadValid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial
    begin
        cfgWrite = 1'b0;
        cfgRead = 1'b0;
        cfgAddr = 8'h00;
        cfgByteEn = 4'h0;
        cfgWriteData = 32'h00000000;
    end
    // One-cycle write; address and data inverted on release so stale values never match
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge core_clk);
        cfgAddr = a;
        cfgByteEn = be;
        cfgWriteData = d;
        cfgWrite = 1'b1;
        @(negedge core_clk);
        cfgWrite = 1'b0;
        cfgAddr = ~a;
        cfgWriteData = ~d;
    endtask
    // One-cycle read; answer stands the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(negedge core_clk);
        cfgAddr = a;
        cfgRead = 1'b1;
        @(negedge core_clk);
        cfgRead = 1'b0;
        cfgAddr = ~a;
        ok = cfgReadValid;
        d = cfgReadData;
    endtask
endmodule

// ---- verification/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, sys_rst, ioEnable, memEnable, serrEnable, downstreamSystemErrorN;
    logic abortValid, abortPosted, abortCanTarget, fwdValid, fwdIsIo, inIoWindow, inMemWindow;
    logic [1:0] pciXMode, delayedPending, vgaIsa;
    logic [31:0] fwdAddr, d, m;
    wire cfgWrite, cfgRead, cfgReadValid, upstreamSystemErrorN, downstreamResetN;
    wire parityCheckEnable, fastBackToBack, abortFillOnes, abortTargetAbort, abortSplitDone;
    wire fwdDone, fwdDownstream;
    wire [7:0] cfgAddr;
    wire [3:0] cfgByteEn, prefetchAddrCap;
    wire [31:0] cfgWriteData, cfgReadData;
    wire [1:0] discardExpired;
    int num_errors, num_checks, cycles, k;
    logic [31:0] shadow [0:5]; // Expected dwords 28h..3ch
    logic [31:0] wm [0:5] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 0, 0, 32'h0b6f00ff};
    logic [7:0] addrs [0:6] = '{8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40};
    logic ok;
    logic [7:0] a;
    logic [3:0] be;
    bcuh_config_upper #(.DT_LONG(64), .DT_SHORT(16)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
        .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid), .pciXMode(pciXMode),
        .ioEnable(ioEnable), .memEnable(memEnable), .serrEnable(serrEnable),
        .delayedPending(delayedPending), .discardExpired(discardExpired),
        .downstreamSystemErrorN(downstreamSystemErrorN),
        .upstreamSystemErrorN(upstreamSystemErrorN), .downstreamResetN(downstreamResetN),
        .parityCheckEnable(parityCheckEnable), .fastBackToBack(fastBackToBack),
        .prefetchAddrCap(prefetchAddrCap), .abortValid(abortValid),
        .abortPosted(abortPosted), .abortCanTarget(abortCanTarget),
        .abortFillOnes(abortFillOnes), .abortTargetAbort(abortTargetAbort),
        .abortSplitDone(abortSplitDone), .fwdValid(fwdValid), .fwdIsIo(fwdIsIo),
        .fwdAddr(fwdAddr), .inIoWindow(inIoWindow), .inMemWindow(inMemWindow),
        .fwdDone(fwdDone), .fwdDownstream(fwdDownstream));
    bcuh_host host_u (.core_clk(core_clk), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
        .cfgReadData(cfgReadData), .cfgReadValid(cfgReadValid));
    // 10 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Hang guard, far above the roughly 900 cycles needed
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want)
        begin
            num_errors++;
            $display("BAD t=%0t got %h want %h", $time, got, want);
        end
    endtask
    // Mapped dwords from the shadow, everything else reads zero
    function automatic logic [31:0] expv(input logic [7:0] x);
        if (x >= 8'h28 && x <= 8'h3c)
            return shadow[(x - 8'h28) >> 2];
        return 32'h0;
    endfunction
    // Forwarding decision from the window, VGA and ISA settings
    function automatic logic fexp();
        logic on, vga;
        on = fwdIsIo ? ioEnable : memEnable;
        vga = fwdIsIo ? (fwdAddr <= 32'hffff && ((fwdAddr[9:0] >= 10'h3b0 && fwdAddr[9:0]
            <= 10'h3bb) || (fwdAddr[9:0] >= 10'h3c0 && fwdAddr[9:0] <= 10'h3df)))
            : (fwdAddr >= 32'ha0000 && fwdAddr <= 32'hbffff);
        if (vgaIsa[1] && vga)
            return on;
        return on && (fwdIsIo ? inIoWindow : inMemWindow)
            && !(vgaIsa[0] && fwdIsIo && fwdAddr <= 32'hffff);
    endfunction
    // Read and compare a whole dword
    task automatic rchk(input logic [7:0] x, input logic [31:0] want);
        host_u.rd(x, d, ok);
        chk({31'h0, ok}, 32'h1);
        chk(d, want);
    endtask
    // Run one discard timer to expiry; L negedges from pending to pulse
    task automatic dt(input int s, input logic [31:0] c, input int want);
        int n;
        host_u.wr(8'h3c, 4'hc, c);
        @(negedge core_clk);
        delayedPending[s] = 1'b1;
        n = 0;
        while (discardExpired[s] !== 1'b1 && n < 200)
        begin
            @(negedge core_clk);
            n++;
        end
        delayedPending[s] = 1'b0;
        chk(n, want);
        chk({31'h0, upstreamSystemErrorN}, {31'h0, ~(c[27] & ~pciXMode[0])});
        host_u.rd(8'h3c, d, ok);
        chk({31'h0, d[26]}, {31'h0, ~pciXMode[0]});
        host_u.wr(8'h3c, 4'h8, c | 32'h04000000);
        host_u.rd(8'h3c, d, ok);
        chk({31'h0, d[26]}, 32'h0);
    endtask
    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        {pciXMode, delayedPending, ioEnable, memEnable, serrEnable} = 0;
        {abortValid, abortPosted, abortCanTarget, fwdValid, fwdIsIo, fwdAddr} = 0;
        {inIoWindow, inMemWindow} = 0;
        downstreamSystemErrorN = 1'b1;
        void'($urandom(32'ha7c4));
        shadow = '{0, 0, 0, 32'h80, 0, 0};
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 7; i++)
            rchk(addrs[i], expv(addrs[i]));
        chk({prefetchAddrCap, 3'h0, fastBackToBack}, 8'h10);
        repeat (60)
        begin
            a = addrs[$urandom_range(6)];
            be = 4'($urandom);
            m = $urandom;
            host_u.wr(a, be, m);
            k = (a - 8'h28) >> 2;
            if (k < 6)
                shadow[k] = (shadow[k] & ~(wm[k] & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}},
                    {8{be[0]}}})) | (m & wm[k] & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
            rchk(a, expv(a));
            chk({downstreamResetN, parityCheckEnable}, {~shadow[5][22], shadow[5][16]});
        end
        for (int v = 0; v < 2; v++)
        begin
            host_u.wr(8'h3c, 4'hc, 32'(v) << 17);
            @(negedge core_clk);
            downstreamSystemErrorN = 1'b0;
            @(negedge core_clk);
            downstreamSystemErrorN = 1'b1;
            chk({31'h0, upstreamSystemErrorN}, 32'(1 - v));
        end
        dt(0, 32'h09000000, 16);
        dt(1, 32'h00000000, 64);
        dt(1, 32'h0a000000, 16);
        pciXMode = 2'b01;
        dt(1, 32'h08000000, 64);
        pciXMode = 2'b00;
        for (int i = 0; i < 16; i++)
        begin
            host_u.wr(8'h3c, 4'h4, 32'(i & 1) << 21);
            pciXMode = {1'b0, i[3]};
            serrEnable = 1'($urandom);
            @(negedge core_clk);
            {abortCanTarget, abortPosted, abortValid} = {i[2], i[1], 1'b1};
            @(negedge core_clk);
            abortValid = 1'b0;
            m[0] = i[3] & ~i[1];
            chk({abortSplitDone, abortFillOnes, abortTargetAbort, ~upstreamSystemErrorN},
                {m[0], ~m[0] & ~i[0], ~m[0] & i[0] & i[2], ~m[0] & i[0] & ~i[2] & serrEnable});
        end
        pciXMode = 2'b00;
        repeat (120)
        begin
            vgaIsa = 2'($urandom);
            host_u.wr(8'h3c, 4'h4, {12'h0, vgaIsa, 18'h0});
            {ioEnable, memEnable, inIoWindow, inMemWindow, fwdIsIo} = 5'($urandom);
            case ($urandom_range(3))
                0: fwdAddr = 32'ha0000 + $urandom_range(32'h1ffff);
                1: fwdAddr = {16'h0, 6'($urandom), 10'h3b0 + 10'($urandom_range(47))};
                2: fwdAddr = {16'h0, 16'($urandom)};
                default: fwdAddr = $urandom;
            endcase
            fwdValid = 1'b1;
            @(negedge core_clk);
            fwdValid = 1'b0;
            chk({fwdDone, fwdDownstream}, {1'b1, fexp()});
        end
        end_of_test();
    end
endmodule
